// >>> design/sdoc_decim.sv
// Multichannel sinc3 plus sinc1 decimator with output coding
// Summary of operation
// - Common two-bit dither setting turns dithering on or off in every modulator.
// - Third-order sinc decimates by its ratio, first-order averages its count.
// - Settling equals three third-order ratios plus (first-order minus one) times it.
// - First-order stage only active above total ratio 512; else passes through.
// - Select codes map to ratios 32..512 and first-order 1, 2, 4, 8.
// - Resolution 17, 20, 23 bits at 32, 64, 128; 24 bits above.
// - Resolution follows only the oversampling select, never the output width.
// - All channels share one oversampling setting and identical resolution.
// - Unsettled outputs are dropped; every data-ready marks settled data.
// - First result after restart comes once the full settling time elapsed.
// - Later data-ready pulses are spaced exactly one output data period.
// - Results are 24-bit two's complement words, most significant bit first.
// - Two-bit width setting picks 16, 24 or 32-bit words; 01 is 24.
// - Overrange clamps to 7fffff masked to the resolution, or to 800000, with no wraparound.
// - DC code scales full-scale modulator density to 8388608 times gain ratio.
// - Below 24 significant bits, results are left justified, low bits zero.
// - While hard reset is low every channel outputs zero.
// - Hard reset clears every filter stage and both output buffer halves.
`include "sdoc_regs.svh"

module sdoc_decim #(
   parameter int NCH = 4,
   parameter int IW  = 29
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_b,
   input  wire sdoc_pkg::sdoc_cfg_t     cfg,
   input  wire logic                    restart,
   input  wire logic [NCH-1:0]          mod_bits,
   input  wire logic [$clog2(NCH)-1:0]  rd_chan,
   output logic                         dither_on,
   output logic                         data_ready,
   output logic                         settling,
   output logic      [4:0]              resolution_bits,
   output logic      [NCH-1:0][23:0]    channel_result,
   output logic      [31:0]             rd_data
);
   import sdoc_pkg::*;

   function automatic logic [3:0] f_log3(input logic [2:0] code);
      f_log3 = (code >= `SDOC_OSR_MAX3_CODE) ? `SDOC_LOG3_MAX
                                              : `SDOC_LOG3_MIN + {1'b0, code};
   endfunction : f_log3

   function automatic logic [1:0] f_log1(input logic [2:0] code);
      f_log1 = (code > `SDOC_OSR_MAX3_CODE) ? code[1:0] : 2'd0;
   endfunction : f_log1

   function automatic logic [4:0] f_res(input logic [2:0] code);
      case (code)
         3'h0:    f_res = `SDOC_RES_OSR32;
         3'h1:    f_res = `SDOC_RES_OSR64;
         3'h2:    f_res = `SDOC_RES_OSR128;
         default: f_res = `SDOC_RES_MAX;
      endcase
   endfunction : f_res

   function automatic logic [31:0] f_present(input logic [23:0] v,
                                             input logic [1:0]  ws);
      case (ws)
         `SDOC_WID_16:  f_present = {16'h0000, v[23:8]};
         `SDOC_WID_24:  f_present = {8'h00, v};
         `SDOC_WID_32:  f_present = {{8{v[23]}}, v};
         default:       f_present = {v, 8'h00};
      endcase
   endfunction : f_present

   // Shared decimation control: one setting for all channels
   logic [2:0]   osr_q;
   logic [8:0]   dec_cnt_q;
   logic [1:0]   skip_q;
   logic [2:0]   grp_q;
   logic         bank_q;
   logic         rd_bank_q;
   sdoc_state_t  st_q;
   sdoc_state_t  st_d;

   wire [2:0]  osr_code   = cfg.oversampling_select;
   wire [3:0]  lg3        = f_log3(osr_code);
   wire [1:0]  lg1        = f_log1(osr_code);
   wire [8:0]  third_order_ratio_m1    = 9'((10'h1 << lg3) - 10'h1);
   wire [2:0]  first_order_ratio_m1    = 3'((4'h1 << lg1) - 4'h1);
   wire [4:0]  total_lg   = 5'(3 * lg3) + {3'b000, lg1};
   wire [4:0]  align_sh   = total_lg - `SDOC_ALIGN_BASE;
   wire [4:0]  res        = f_res(osr_code);
   wire [23:0] keep_mask  = 24'hffffff << (`SDOC_RES_MAX - res);
   wire        restart_w  = restart || (osr_code != osr_q);
   wire        dec_tick   = (dec_cnt_q == third_order_ratio_m1);
   wire        grp_first  = (grp_q == 3'd0);
   wire        grp_last   = (grp_q == first_order_ratio_m1);
   wire        emit       = dec_tick && !restart_w && grp_last &&
                            (st_q != SDOC_ST_SKIP);

   assign dither_on       = (cfg.dither_level != 2'b00);
   assign resolution_bits = res;

   always_comb begin
      st_d = st_q;
      case (st_q)
         SDOC_ST_SKIP: begin
            if (dec_tick && skip_q == `SDOC_SKIP_OUTPUTS - 2'd1) begin
               st_d = SDOC_ST_FILL;
            end
         end
         SDOC_ST_FILL: begin
            if (emit) begin
               st_d = SDOC_ST_RUN;
            end
         end
         SDOC_ST_RUN:  st_d = SDOC_ST_RUN;
         default:      st_d = SDOC_ST_SKIP;
      endcase
      if (restart_w) begin
         st_d = SDOC_ST_SKIP;
      end
   end

   assign settling = (st_q != SDOC_ST_RUN);

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         osr_q <= `SDOC_OSR_CODE_RST;
         st_q  <= SDOC_ST_SKIP;
      end else begin
         osr_q <= osr_code;
         st_q  <= st_d;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dec_cnt_q <= '0;
         skip_q    <= '0;
         grp_q     <= '0;
      end else if (restart_w) begin
         dec_cnt_q <= '0;
         skip_q    <= '0;
         grp_q     <= '0;
      end else if (dec_tick) begin
         dec_cnt_q <= '0;
         if (st_q == SDOC_ST_SKIP) begin
            skip_q <= skip_q + 2'd1;
         end else begin
            grp_q  <= grp_last ? 3'd0 : grp_q + 3'd1;
         end
      end else begin
         dec_cnt_q <= dec_cnt_q + 9'd1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         data_ready <= 1'b0;
         bank_q     <= 1'b0;
         rd_bank_q  <= 1'b0;
      end else begin
         data_ready <= emit;
         if (emit) begin
            bank_q    <= ~bank_q;
            rd_bank_q <= bank_q;
         end
      end
   end

   // Per-channel filter and coding
   logic [NCH-1:0][31:0] present_w;
   logic [NCH-1:0][23:0] code_w;
   logic signed [39:0]   scaled_w [NCH];

   for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
      logic signed [IW-1:0] in1_q, in2_q, in3_q;
      logic signed [IW-1:0] cd1_q, cd2_q, cd3_q;
      logic signed [31:0]   acc_q;

      wire signed [IW-1:0] x_w  = mod_bits[ch] ? IW'(1) : -IW'(1);
      // Combs take the next integrator value so the first window is full
      wire signed [IW-1:0] i3n_w = in3_q + in2_q;
      wire signed [IW-1:0] c1_w = i3n_w - cd1_q;
      wire signed [IW-1:0] c2_w = c1_w - cd2_q;
      wire signed [IW-1:0] c3_w = c2_w - cd3_q;
      wire signed [31:0]   s3_w = 32'(c3_w);
      wire signed [31:0]   sum_w = grp_first ? s3_w : acc_q + s3_w;
      wire signed [39:0]   wide_w = 40'(sum_w) <<< `SDOC_ALIGN_PRE;

      assign scaled_w[ch] = wide_w >>> align_sh;
      assign code_w[ch] =
         ((scaled_w[ch] > `SDOC_POS_LIM) ? `SDOC_POS_SAT :
          (scaled_w[ch] < `SDOC_NEG_LIM) ? `SDOC_NEG_SAT :
          scaled_w[ch][23:0]) & keep_mask;
      assign present_w[ch] = f_present(code_w[ch], cfg.width_select);

      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            in1_q <= '0;
            in2_q <= '0;
            in3_q <= '0;
         end else if (restart_w) begin
            in1_q <= '0;
            in2_q <= '0;
            in3_q <= '0;
         end else begin
            in1_q <= in1_q + x_w;
            in2_q <= in2_q + in1_q;
            in3_q <= in3_q + in2_q;
         end
      end

      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            cd1_q <= '0;
            cd2_q <= '0;
            cd3_q <= '0;
            acc_q <= '0;
         end else if (restart_w) begin
            cd1_q <= '0;
            cd2_q <= '0;
            cd3_q <= '0;
            acc_q <= '0;
         end else if (dec_tick) begin
            cd1_q <= i3n_w;
            cd2_q <= c1_w;
            cd3_q <= c2_w;
            acc_q <= sum_w;
         end
      end

      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            channel_result[ch] <= '0;
         end else if (emit) begin
            channel_result[ch] <= code_w[ch];
         end
      end
   end

   sdoc_result_mem #(
      .NCH (NCH),
      .W   (32)
   ) u_mem (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .wr_en    (emit),
      .wr_bank  (bank_q),
      .wr_words (present_w),
      .rd_bank  (rd_bank_q),
      .rd_chan  (rd_chan),
      .rd_data  (rd_data)
   );

   // Helper counters for the checks below
   logic [15:0] gap_q;
   logic        seen_q;
   wire  [15:0] settle_cyc = `SDOC_SETTLE_MULT * (16'(third_order_ratio_m1) + 16'd1) +
                             16'(first_order_ratio_m1) * (16'(third_order_ratio_m1) + 16'd1);
   wire  [15:0] period_cyc = (16'(third_order_ratio_m1) + 16'd1) << lg1;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         gap_q  <= '0;
         seen_q <= 1'b0;
      end else if (restart_w) begin
         gap_q  <= '0;
         seen_q <= 1'b0;
      end else if (data_ready) begin
         gap_q  <= 16'd1;
         seen_q <= 1'b1;
      end else begin
         gap_q  <= gap_q + 16'd1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   dither_common_a: assert property (
      $changed(cfg.dither_level) |-> dither_on == (cfg.dither_level != 0))
      else $error("dither enable does not follow setting");

   ready_pulse_a: assert property (
      data_ready |=> !data_ready)
      else $error("data ready longer than one cycle");

   ready_settled_a: assert property (
      emit |-> st_q != SDOC_ST_SKIP && skip_q == 2'd2)
      else $error("unsettled result emitted");

   first_latency_a: assert property (
      data_ready && !seen_q |-> gap_q == settle_cyc)
      else $error("first result not at settling time");

   ready_spacing_a: assert property (
      data_ready && seen_q |-> gap_q == period_cyc)
      else $error("data ready spacing wrong");

   pos_clamp_a: assert property (
      emit && scaled_w[0] > `SDOC_POS_LIM |=>
         channel_result[0] == (`SDOC_POS_SAT & $past(keep_mask)))
      else $error("positive overrange not clamped");

   neg_clamp_a: assert property (
      emit && scaled_w[1] <= `SDOC_NEG_LIM |=>
         channel_result[1] == `SDOC_NEG_SAT)
      else $error("negative overrange not clamped");

   left_just_a: assert property (
      data_ready && !$changed(osr_code) |->
         (channel_result[0] & ~keep_mask) == 24'h000000)
      else $error("low bits not zero");

   width_read_a: assert property (
      data_ready && $past(cfg.width_select) == `SDOC_WID_16 |=>
         rd_data[31:16] == 16'h0000)
      else $error("16-bit word not right aligned");

   cov_first: cover property (data_ready && !seen_q);
   cov_sinc1: cover property (data_ready && seen_q && lg1 == 2'd3);
   cov_possat: cover property (emit && scaled_w[0] > `SDOC_POS_LIM);
   cov_restart: cover property (seen_q ##1 restart_w);

endmodule : sdoc_decim

// >>> design/sdoc_pkg.sv
// Types of the decimation and output coding block
package sdoc_pkg;

   typedef struct packed {
      logic [1:0] dither_level;
      logic [2:0] oversampling_select;
      logic [1:0] width_select;
   } sdoc_cfg_t;

   typedef enum logic [1:0] {
      SDOC_ST_SKIP = 2'b00,
      SDOC_ST_FILL = 2'b01,
      SDOC_ST_RUN  = 2'b10
   } sdoc_state_t;

endpackage : sdoc_pkg

// >>> design/sdoc_regs.svh
// Constants of the decimation and output coding block
`ifndef SDOC_REGS_SVH
`define SDOC_REGS_SVH

`define SDOC_RES_MAX       5'd24
`define SDOC_RES_OSR32     5'd17
`define SDOC_RES_OSR64     5'd20
`define SDOC_RES_OSR128    5'd23
`define SDOC_POS_SAT       24'h7fffff
`define SDOC_NEG_SAT       24'h800000
`define SDOC_POS_LIM       40'sh00007fffff
`define SDOC_NEG_LIM       -40'sh0000800000
`define SDOC_WID_16        2'h0
`define SDOC_WID_24        2'h1
`define SDOC_WID_32        2'h2
`define SDOC_WID_32L       2'h3
`define SDOC_OSR_CODE_RST  3'h3
`define SDOC_OSR_MAX3_CODE 3'h4
`define SDOC_LOG3_MIN      4'd5
`define SDOC_LOG3_MAX      4'd9
`define SDOC_SETTLE_MULT   16'd3
`define SDOC_SKIP_OUTPUTS  2'd2
`define SDOC_ALIGN_PRE     8
`define SDOC_ALIGN_BASE    5'd15

`endif

// >>> design/sdoc_result_mem.sv
// Double output buffer of presented channel words
module sdoc_result_mem #(
   parameter int NCH = 4,
   parameter int W   = 32
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_b,
   input  wire logic                    wr_en,
   input  wire logic                    wr_bank,
   input  wire logic [NCH-1:0][W-1:0]   wr_words,
   input  wire logic                    rd_bank,
   input  wire logic [$clog2(NCH)-1:0]  rd_chan,
   output logic      [W-1:0]            rd_data
);
   import sdoc_pkg::*;

   logic [W-1:0] mem_q [2][NCH];

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         for (int b = 0; b < 2; b++) begin
            for (int c = 0; c < NCH; c++) begin
               mem_q[b][c] <= '0;
            end
         end
      end else if (wr_en) begin
         for (int c = 0; c < NCH; c++) begin
            mem_q[wr_bank][c] <= wr_words[c];
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_q[rd_bank][rd_chan];
      end
   end

endmodule : sdoc_result_mem

// >>> sim/sdoc_mod_model.sv
// Modulator bitstream model feeding four decimator channels
module sdoc_mod_model (
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   output logic      [3:0]  mod_bits
);
   timeunit 1ns;
   timeprecision 1ps;
   logic alt_q;

   initial begin
      mod_bits = 4'h0;
      alt_q    = 1'b0;
   end

   // Ch0 full plus, ch1 full minus, ch2 zero mean, ch3 noise
   always @(negedge clk_sys) begin
      alt_q    <= ~alt_q;
      mod_bits <= {1'($urandom), alt_q, 1'b0, 1'b1};
   end
endmodule : sdoc_mod_model

// >>> sim/tb_sinc_decimation_output_coding.sv
// Self-checking bench of the multichannel decimator and output coding
module tb_sinc_decimation_output_coding;
   timeunit 1ns;
   timeprecision 1ps;
   import sdoc_pkg::*;
   localparam int NCH = 4;
   logic                  clk_sys;
   logic                  rst_b;
   sdoc_cfg_t             cfg;
   logic                  restart;
   logic [NCH-1:0]        mod_bits;
   logic [1:0]            rd_chan;
   logic                  dither_on;
   logic                  data_ready;
   logic                  settling;
   logic [4:0]            resolution_bits;
   logic [NCH-1:0][23:0]  channel_result;
   logic [31:0]           rd_data;
   int                    n_errors;
   int                    n_compared;
   int                    cycles;
   int                    n;
   int                    early;

   sdoc_decim #(
      .NCH (NCH),
      .IW  (29)
   ) dut_u (
      .clk_sys         (clk_sys),
      .rst_b           (rst_b),
      .cfg             (cfg),
      .restart         (restart),
      .mod_bits        (mod_bits),
      .rd_chan         (rd_chan),
      .dither_on       (dither_on),
      .data_ready      (data_ready),
      .settling        (settling),
      .resolution_bits (resolution_bits),
      .channel_result  (channel_result),
      .rd_data         (rd_data)
   );

   sdoc_mod_model model_u (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .mod_bits (mod_bits)
   );

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   // Hang guard, well above the summed conversion times
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         $display("MISMATCH timeout expected 0 seen %0d", cycles);
         end_of_test();
      end
   end

   task automatic chk_val(string what, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val

   task automatic chk_cnt(string what, int exp, int got);
      n_compared++;
      if (got != exp) begin
         n_errors++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_cnt

   function automatic int ratio3(int code);
      return 32 << ((code > 4) ? 4 : code);
   endfunction : ratio3

   function automatic int ratio1(int code);
      return (code > 4) ? (1 << (code - 4)) : 1;
   endfunction : ratio1

   function automatic int res_of(int code);
      return (code == 0) ? 17 : (code == 1) ? 20 : (code == 2) ? 23 : 24;
   endfunction : res_of

   function automatic logic [31:0] present(logic [23:0] v, logic [1:0] ws);
      case (ws)
         2'h0: return {16'h0, v[23:8]};
         2'h1: return {8'h0, v};
         2'h2: return {{8{v[23]}}, v};
         default: return {v, 8'h00};
      endcase
   endfunction : present

   task automatic wait_dr(output int cnt, output int unset);
      cnt = 0;
      unset = 0;
      do begin
         @(negedge clk_sys);
         cnt++;
         if (data_ready !== 1'b1 && settling !== 1'b1) unset++;
      end while (data_ready !== 1'b1 && cnt < 6000);
   endtask : wait_dr

   // Called at the falling edge where data_ready is high
   task automatic check_results(int code, bit rd);
      logic [23:0] m;
      logic [23:0] q[$];
      m = 24'hffffff << (24 - res_of(code));
      q = '{24'h7fffff & m, 24'h800000, 24'h000000};
      for (int c = 0; c < 3; c++) begin
         chk_val("result", 32'(q[c]), 32'(channel_result[c]));
      end
      chk_val("low bits", 32'h0, 32'(channel_result[3] & ~m));
      for (int c = 0; c < 3 && rd; c++) begin
         rd_chan = 2'(c);
         @(negedge clk_sys);
         chk_val("rd_data", present(q[c], cfg.width_select), rd_data);
      end
   endtask : check_results

   task automatic check_reset();
      for (int c = 0; c < NCH; c++) begin
         chk_val("reset result", 32'h0, 32'(channel_result[c]));
      end
      chk_val("reset rd_data", 32'h0, rd_data);
      chk_val("reset flags", 32'h1, {30'h0, data_ready, settling});
   endtask : check_reset

   initial begin
      rst_b = 1'b0;
      restart = 1'b0;
      rd_chan = 2'h0;
      cfg = '{dither_level: 2'h3, oversampling_select: 3'h0, width_select: 2'h1};
      n_errors = 0;
      n_compared = 0;
      cycles = 0;
      void'($urandom(68));
      repeat (9) @(negedge clk_sys);
      check_reset();
      @(negedge clk_sys);
      rst_b = 1'b1;
      for (int code = 0; code < 8; code++) begin
         @(negedge clk_sys);
         cfg.oversampling_select = 3'(code);
         cfg.width_select = 2'(code % 4);
         cfg.dither_level = 2'($urandom);
         rd_chan = 2'($urandom);
         restart = 1'b1;
         @(negedge clk_sys);
         restart = 1'b0;
         chk_val("dither_on", {31'h0, cfg.dither_level != 2'h0}, {31'h0, dither_on});
         chk_val("resolution", 32'(res_of(code)), {27'h0, resolution_bits});
         wait_dr(n, early);
         chk_cnt("first latency", 3 * ratio3(code) + (ratio1(code) - 1) * ratio3(code), n);
         chk_cnt("early valid", 0, early);
         check_results(code, 1'b0);
         wait_dr(n, early);
         chk_cnt("spacing", ratio3(code) * ratio1(code), n);
         chk_cnt("settled gap", ratio3(code) * ratio1(code) - 1, early);
         check_results(code, 1'b1);
         $display("test osr code %0d done", code);
      end
      @(negedge clk_sys);
      rst_b = 1'b0;
      @(negedge clk_sys);
      check_reset();
      $display("test mid-run reset done");
      rst_b = 1'b1;
      end_of_test();
   end
endmodule : tb_sinc_decimation_output_coding
